// file: design/epbd_top.v
// Purpose : external port bank decoder, arbiter and access sequencer
// Assumes : one clock i_clk at 20 MHz, asynchronous active-high reset
// Notes   : one access outstanding at a time; answers leave through a
//           two-entry buffer so a stalled receiver loses no word
`timescale 1ns/10ps
`include "epbd_map.vh"

module epbd_top #(
   parameter DW = 64
) (
   // clock and reset
   input  wire          i_clk,
   input  wire          i_rst,
   // core request
   input  wire          i_core_valid,
   input  wire [31:0]   i_core_addr,
   input  wire          i_core_we,
   input  wire [DW-1:0] i_core_wdata,
   input  wire          i_core_fetch,
   input  wire          i_core_cmode,
   input  wire          i_core_simd,
   output reg           o_core_ready,
   // dma request
   input  wire          i_dma_valid,
   input  wire [31:0]   i_dma_addr,
   input  wire          i_dma_we,
   input  wire [DW-1:0] i_dma_wdata,
   output reg           o_dma_ready,
   // bank configuration
   input  wire [3:0]    i_bank_sdram_mode,
   input  wire [11:0]   i_sdram_size,
   input  wire [15:0]   i_async_wait,
   input  wire [15:0]   i_sdram_ext,
   // answer
   input  wire          i_rsp_ready,
   output reg           o_rsp_valid,
   output reg           o_rsp_dma,
   output reg           o_rsp_err,
   output reg  [DW-1:0] o_rsp_data,
   output reg  [1:0]    o_rsp_icnt,
   // external pins
   output reg  [3:0]    o_bank_select_n,
   output reg  [31:0]   o_ext_addr,
   output reg           o_ext_we_n,
   output reg           o_ext_sdram,
   output reg  [DW-1:0] o_epd_out,
   output reg           o_epd_oe,
   input  wire [DW-1:0] i_epd_in
);

   // ****************************************************************
   // states
   // ****************************************************************
   localparam [1:0] S_IDLE  = 2'h0;
   localparam [1:0] S_GRANT = 2'h1;
   localparam [1:0] S_ACC   = 2'h2;
   localparam [1:0] S_DONE  = 2'h3;

   // ****************************************************************
   // decode: returns {hit, bank}
   // ****************************************************************
   function [2:0] bank_decode;
      input [31:0] a;
      input [3:0]  sdm;
      input [11:0] sz;
      reg   [1:0]  b;
      reg   [2:0]  code;
      reg   [25:0] lim;
      reg          hit;
      begin
         b    = a[27:26];
         code = sz[b*3 +: 3];
         if (code > `EPBD_SDR_SIZE_MAX) begin
            code = `EPBD_SDR_SIZE_MAX;
         end
         // 256M bytes fills the whole 64M-word slot and overflows lim
         lim  = `EPBD_SDR_MIN_WORDS << code;
         if (a[31:28] != 4'h0) begin
            hit = 1'b0;
         end else if (sdm[b]) begin
            hit = (code == `EPBD_SDR_SIZE_MAX) ? 1'b1
                : (a[25:0] < lim);
         end else begin
            hit = (a[25:0] < `EPBD_ASYNC_WORDS);
         end
         // bank 0 never starts below its fixed base in either mode
         if (b == 2'h0 && a < `EPBD_BANK0_BASE) begin
            hit = 1'b0;
         end
         bank_decode = {hit, b};
      end
   endfunction

   // ****************************************************************
   // fetch window check
   // ****************************************************************
   function fetch_ok;
      input [31:0] a;
      input        cmode;
      begin
         if (cmode) begin
            fetch_ok = (a >= `EPBD_COMPRESSED_INSTRUCTION_MODE_FIRST)
                     && (a <= `EPBD_COMPRESSED_INSTRUCTION_MODE_LAST);
         end else begin
            fetch_ok = (a >= `EPBD_ISA_FIRST)
                     && (a <= `EPBD_ISA_LAST);
         end
      end
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   reg [1:0]    state_r;
   reg          sel_dma_r;
   reg          last_dma_r;
   reg [4:0]    cnt_r;
   reg          sdr_r;
   reg          simd_r;
   reg          we_r;
   reg [1:0]    icnt_r;
   reg          err_r;
   reg [DW-1:0] rdata_r;
   reg [DW-1:0] epd_s1_r;
   reg [DW-1:0] epd_s2_r;
   reg          spare_v_r;
   reg          spare_dma_r;
   reg          spare_err_r;
   reg [DW-1:0] spare_data_r;
   reg [1:0]    spare_icnt_r;

   // ****************************************************************
   // request mux and decode
   // ****************************************************************
   reg  [31:0]   req_addr;
   reg           req_we;
   reg  [DW-1:0] req_wdata;
   reg           req_fetch;
   reg           req_cmode;
   reg           req_simd;
   reg  [2:0]    dec;
   reg           req_hit;
   reg           req_sdr;
   reg  [4:0]    req_cnt;

   always @* begin
      if (sel_dma_r) begin
         req_addr  = i_dma_addr;
         req_we    = i_dma_we;
         req_wdata = i_dma_wdata;
         req_fetch = 1'b0;
         req_cmode = 1'b0;
         req_simd  = 1'b0;
      end else begin
         req_addr  = i_core_addr;
         req_we    = i_core_we;
         req_wdata = i_core_wdata;
         req_fetch = i_core_fetch;
         req_cmode = i_core_cmode;
         req_simd  = i_core_simd;
      end
      dec     = bank_decode(req_addr, i_bank_sdram_mode, i_sdram_size);
      req_hit = dec[2];
      // code runs from bank 0 only, and only inside its mode's window
      if (req_fetch && (dec[1:0] != 2'h0
          || !fetch_ok(req_addr, req_cmode))) begin
         req_hit = 1'b0;
      end
      req_sdr = i_bank_sdram_mode[dec[1:0]];
      // the sync stages add latency, so every access waits for them
      if (req_sdr) begin
         // one spare bit: base plus the largest extra wait needs five bits
         req_cnt = {1'b0, `EPBD_SDR_BASE_CYC}
                 + {1'b0, i_sdram_ext[dec[1:0]*4 +: 4]};
      end else begin
         req_cnt = {1'b0, `EPBD_SYNC_CYC}
                 + {1'b0, i_async_wait[dec[1:0]*4 +: 4]};
      end
   end

   // ****************************************************************
   // arbiter and sequencer
   // ****************************************************************
   wire both_req  = i_core_valid & i_dma_valid;
   wire pick_dma  = both_req ? ~last_dma_r : i_dma_valid;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r         <= S_IDLE;
         sel_dma_r       <= 1'b0;
         last_dma_r      <= 1'b1;
         o_core_ready    <= 1'b0;
         o_dma_ready     <= 1'b0;
         cnt_r           <= 5'h00;
         sdr_r           <= 1'b0;
         simd_r          <= 1'b0;
         we_r            <= 1'b0;
         icnt_r          <= `EPBD_ICNT_NONE;
         err_r           <= 1'b0;
         rdata_r         <= {DW{1'b0}};
         o_bank_select_n <= `EPBD_SEL_IDLE;
         o_ext_addr      <= 32'h0000_0000;
         o_ext_we_n      <= 1'b1;
         o_ext_sdram     <= 1'b0;
         o_epd_out       <= {DW{1'b0}};
         o_epd_oe        <= 1'b0;
      end else begin
         o_core_ready <= 1'b0;
         o_dma_ready  <= 1'b0;
         case (state_r)
            S_IDLE: begin
               // a grant waits for room so the answer can never be lost
               if ((i_core_valid | i_dma_valid) && !spare_v_r) begin
                  sel_dma_r    <= pick_dma;
                  last_dma_r   <= pick_dma;
                  o_dma_ready  <= pick_dma;
                  o_core_ready <= ~pick_dma;
                  state_r      <= S_GRANT;
               end
            end
            S_GRANT: begin
               we_r    <= req_we;
               sdr_r   <= req_sdr;
               simd_r  <= req_simd & req_sdr;
               icnt_r  <= !req_fetch ? `EPBD_ICNT_NONE
                        : req_cmode ? `EPBD_ICNT_PACKED
                        : `EPBD_ICNT_FIXED;
               rdata_r <= {DW{1'b0}};
               if (req_hit) begin
                  err_r           <= 1'b0;
                  cnt_r           <= req_cnt;
                  o_bank_select_n <= ~(4'h1 << dec[1:0]);
                  o_ext_addr      <= req_addr;
                  o_ext_sdram     <= req_sdr;
                  o_ext_we_n      <= ~req_we;
                  o_epd_oe        <= req_we;
                  o_epd_out       <= (req_simd & req_sdr) ? req_wdata
                                   : {{(DW-32){1'b0}}, req_wdata[31:0]};
                  state_r         <= S_ACC;
               end else begin
                  err_r   <= 1'b1;
                  state_r <= S_DONE;
               end
            end
            S_ACC: begin
               if (cnt_r == 5'h00) begin
                  if (!we_r) begin
                     rdata_r <= simd_r ? epd_s2_r
                              : (icnt_r != `EPBD_ICNT_NONE)
                              ? {{(DW-48){1'b0}}, epd_s2_r[47:0]}
                              : {{(DW-32){1'b0}}, epd_s2_r[31:0]};
                  end
                  o_bank_select_n <= `EPBD_SEL_IDLE;
                  o_ext_we_n      <= 1'b1;
                  o_epd_oe        <= 1'b0;
                  state_r         <= S_DONE;
               end else begin
                  cnt_r <= cnt_r - 5'h01;
               end
            end
            S_DONE: begin
               state_r <= S_IDLE;
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // data pin synchroniser
   // ****************************************************************
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         epd_s1_r <= {DW{1'b0}};
         epd_s2_r <= {DW{1'b0}};
      end else begin
         epd_s1_r <= i_epd_in;
         epd_s2_r <= epd_s1_r;
      end
   end

   // ****************************************************************
   // two-entry answer buffer: output stage plus one spare
   // ****************************************************************
   wire push = (state_r == S_DONE);
   wire pop  = o_rsp_valid & i_rsp_ready;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rsp_valid  <= 1'b0;
         o_rsp_dma    <= 1'b0;
         o_rsp_err    <= 1'b0;
         o_rsp_data   <= {DW{1'b0}};
         o_rsp_icnt   <= `EPBD_ICNT_NONE;
         spare_v_r    <= 1'b0;
         spare_dma_r  <= 1'b0;
         spare_err_r  <= 1'b0;
         spare_data_r <= {DW{1'b0}};
         spare_icnt_r <= `EPBD_ICNT_NONE;
      end else begin
         if (pop && spare_v_r) begin
            o_rsp_dma  <= spare_dma_r;
            o_rsp_err  <= spare_err_r;
            o_rsp_data <= spare_data_r;
            o_rsp_icnt <= spare_icnt_r;
            spare_v_r  <= push;
         end else if (push && (!o_rsp_valid || pop)) begin
            o_rsp_valid <= 1'b1;
            o_rsp_dma   <= sel_dma_r;
            o_rsp_err   <= err_r;
            o_rsp_data  <= rdata_r;
            o_rsp_icnt  <= icnt_r;
         end else if (push) begin
            spare_v_r <= 1'b1;
         end else if (pop) begin
            o_rsp_valid <= 1'b0;
         end
         if (push) begin
            spare_dma_r  <= sel_dma_r;
            spare_err_r  <= err_r;
            spare_data_r <= rdata_r;
            spare_icnt_r <= icnt_r;
         end
      end
   end

endmodule // epbd_top

// file: design/epbd_map.vh
// Purpose : constants of the external port bank decoder
// Assumes : addresses are 32-bit word addresses
// Notes   : definitions only
`ifndef EPBD_MAP_VH
`define EPBD_MAP_VH

// ********************************************************************
// address map
// ********************************************************************
`define EPBD_BANK0_BASE    32'h0020_0000
`define EPBD_ASYNC_WORDS   26'h080_0000
`define EPBD_SDR_MIN_WORDS 26'h010_0000
`define EPBD_SDR_SIZE_MAX  3'h6
`define EPBD_ISA_FIRST     32'h0020_0000
`define EPBD_ISA_LAST      32'h005F_FFFF
`define EPBD_COMPRESSED_INSTRUCTION_MODE_FIRST    32'h0060_0000
`define EPBD_COMPRESSED_INSTRUCTION_MODE_LAST     32'h00FF_FFFF

// ********************************************************************
// timing and encodings
// ********************************************************************
`define EPBD_SYNC_CYC      4'h2
`define EPBD_SDR_BASE_CYC  4'h3
`define EPBD_ICNT_NONE     2'h0
`define EPBD_ICNT_FIXED    2'h1
`define EPBD_ICNT_PACKED   2'h3
`define EPBD_SEL_IDLE      4'hF

`endif

// file: verif/epbd_mem_model.sv
// Purpose : memory on the far side of the external port
// Assumes : one 64-bit wide, word addressed part behind every select
// Notes   : a released bus shows a pattern that flips every cycle
`timescale 1ns/10ps
module epbd_mem_model (
   // pins from the port
   input  wire        i_clk,
   input  wire [3:0]  i_sel_n,
   input  wire [31:0] i_addr,
   input  wire        i_oe,
   // read data to the port
   output wire [63:0] o_data
);
   reg [63:0] junk_r = 64'h5A5A5A5A5A5A5A5A;
   always @(posedge i_clk) junk_r <= ~junk_r;
   // read word follows the word address, so a wrong address shows up
   assign o_data = (&i_sel_n || i_oe) ? junk_r : {~i_addr, i_addr};
endmodule // epbd_mem_model

// file: verif/epbd_top_asserts.sv
// Purpose : port-level checks of the bank decoder
// Assumes : wait settings stay still while an access runs
// Notes   : select-low length is counted in helper logic
`timescale 1ns/10ps
module epbd_top_asserts #(
   parameter DW = 64
) (
   // clock, reset and inputs
   input wire          i_clk,
   input wire          i_rst,
   input wire [3:0]    i_bank_sdram_mode,
   input wire [15:0]   i_async_wait,
   input wire [15:0]   i_sdram_ext,
   input wire          i_rsp_ready,
   // outputs
   input wire          o_core_ready,
   input wire          o_dma_ready,
   input wire          o_rsp_valid,
   input wire          o_rsp_dma,
   input wire [DW-1:0] o_rsp_data,
   input wire [3:0]    o_bank_select_n,
   input wire [31:0]   o_ext_addr,
   input wire          o_ext_we_n,
   input wire          o_ext_sdram,
   input wire          o_epd_oe
);
   reg  [4:0] cnt_r;
   reg  [1:0] bank_r;
   reg        sd_r;
   wire       idle = &o_bank_select_n;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_r <= 5'h00;
         bank_r <= 2'h0;
         sd_r <= 1'b0;
      end else begin
         cnt_r <= idle ? 5'h00 : cnt_r + 5'h01;
         if (!idle) begin
            bank_r <= o_ext_addr[27:26];
            sd_r <= o_ext_sdram;
         end
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   chk_sel_onehot: assert property ($onehot0(~o_bank_select_n))
      else $error("more than one bank select low");
   chk_sel_bank: assert property (
      !idle |-> o_bank_select_n == ~(4'h1 << o_ext_addr[27:26]))
      else $error("select does not match the address bank");
   chk_ctrl_kind: assert property (
      !idle |-> o_ext_sdram == i_bank_sdram_mode[o_ext_addr[27:26]])
      else $error("wrong controller serves the bank");
   chk_sel_length: assert property ($rose(idle) |-> cnt_r == (sd_r ?
      {1'b0, i_sdram_ext[{bank_r, 2'b00} +: 4]} + 5'h04 :
      {1'b0, i_async_wait[{bank_r, 2'b00} +: 4]} + 5'h03))
      else $error("select low time does not follow the bank wait");
   chk_addr_hold: assert property (
      !idle && $stable(o_bank_select_n) |->
      $stable(o_ext_addr) && $stable(o_ext_we_n))
      else $error("address moved during an access");
   chk_oe_write: assert property (o_epd_oe |-> !o_ext_we_n && !idle)
      else $error("data bus driven outside a write cycle");
   chk_grant_one: assert property (!(o_core_ready && o_dma_ready))
      else $error("core and dma granted together");
   chk_rsp_hold: assert property (o_rsp_valid && !i_rsp_ready |=>
      o_rsp_valid && $stable(o_rsp_data) && $stable(o_rsp_dma))
      else $error("stalled answer changed or vanished");
endmodule // epbd_top_asserts
bind epbd_top epbd_top_asserts #(.DW(DW)) epbd_top_asserts_i (
   .i_clk(i_clk), .i_rst(i_rst), .i_bank_sdram_mode(i_bank_sdram_mode),
   .i_async_wait(i_async_wait), .i_sdram_ext(i_sdram_ext),
   .i_rsp_ready(i_rsp_ready), .o_core_ready(o_core_ready),
   .o_dma_ready(o_dma_ready), .o_rsp_valid(o_rsp_valid),
   .o_rsp_dma(o_rsp_dma), .o_rsp_data(o_rsp_data),
   .o_bank_select_n(o_bank_select_n), .o_ext_addr(o_ext_addr),
   .o_ext_we_n(o_ext_we_n), .o_ext_sdram(o_ext_sdram),
   .o_epd_oe(o_epd_oe));

// file: verif/testbench.sv
// Purpose : self-checking bench of the external port bank decoder
// Assumes : one memory model behind all four selects
// Notes   : every answer is judged as it arrives
`timescale 1ns/10ps
module testbench;
   reg         clk = 1'b0, rst = 1'b1, rr = 1'b1;
   reg         cv = 1'b0, cwe = 1'b0, cf = 1'b0, cm = 1'b0, cs = 1'b0;
   reg         dv = 1'b0, dwe = 1'b0;
   reg  [31:0] ca = 32'h0, da = 32'h0;
   reg  [63:0] cwd = 64'h0, dwd = 64'h0, last_out = 64'h0;
   reg  [3:0]  mode = 4'h0, sel_lo = 4'hF;
   reg  [11:0] size = 12'hDB6;
   reg  [15:0] aw = 16'h3210, se = 16'h2010;
   wire        cr, dr, rv, rd, re, we_n, esd, eoe;
   wire [1:0]  icnt;
   wire [3:0]  sel_n;
   wire [31:0] ea;
   wire [63:0] rdata, eout, ein;
   integer     num_errors = 0, checks_done = 0, n;
   epbd_top epbd_top_i (
      .i_clk(clk), .i_rst(rst), .i_core_valid(cv), .i_core_addr(ca),
      .i_core_we(cwe), .i_core_wdata(cwd), .i_core_fetch(cf),
      .i_core_cmode(cm), .i_core_simd(cs), .o_core_ready(cr),
      .i_dma_valid(dv), .i_dma_addr(da), .i_dma_we(dwe),
      .i_dma_wdata(dwd), .o_dma_ready(dr), .i_bank_sdram_mode(mode),
      .i_sdram_size(size), .i_async_wait(aw), .i_sdram_ext(se),
      .i_rsp_ready(rr), .o_rsp_valid(rv), .o_rsp_dma(rd),
      .o_rsp_err(re), .o_rsp_data(rdata), .o_rsp_icnt(icnt),
      .o_bank_select_n(sel_n), .o_ext_addr(ea), .o_ext_we_n(we_n),
      .o_ext_sdram(esd), .o_epd_out(eout), .o_epd_oe(eoe), .i_epd_in(ein));
   epbd_mem_model epbd_mem_model_i (
      .i_clk(clk), .i_sel_n(sel_n), .i_addr(ea), .i_oe(eoe), .o_data(ein));
   always #25 clk = ~clk;
   // remember which select went low and what a write drove
   always @(posedge clk) begin
      if (sel_n !== 4'hF) sel_lo <= sel_n;
      if (eoe === 1'b1) last_out <= eout;
   end
   task finish_test;
      begin
         $display("checks %0d errors %0d", checks_done, num_errors);
         if (num_errors == 0 && checks_done > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   task chk(input [65:0] g, input [65:0] e);
      begin
         checks_done++;
         if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   // one access: k = {write, fetch, compressed, simd}, h = address hits
   task req(input d, input [3:0] k, input h, input [31:0] a);
      reg        g;
      reg [63:0] x;
      begin
         sel_lo = 4'hF;
         if (d) {dv, da, dwe, dwd} = {1'b1, a, k[3], a, ~a};
         else {cv, ca, cwe, cf, cm, cs, cwd} = {1'b1, a, k, a, ~a};
         x = k[2] ? {16'h0000, ~a[15:0], a} : {32'h00000000, a};
         if (k[0] && mode[a[27:26]]) x = {~a, a};
         if (k[3] || !h) x = 64'h0;
         for (n = 0; n < 40 && (cv | dv); n++) begin
            @(negedge clk);
            g = d ? dr : cr;
            @(posedge clk);
            #1;
            if (g === 1'b1) {cv, dv} = 2'h0;
         end
         for (n = 0; n < 60 && rv !== 1'b1; n++) begin
            @(posedge clk);
            #1;
         end
         if (rv !== 1'b1 || cv || dv) begin
            num_errors++;
            finish_test;
         end
         chk(rdata, x);
         chk({re, icnt}, {~h, k[2] & k[1], k[2]});
         chk(rd, d);
         chk(sel_lo, h ? 4'(~(4'h1 << a[27:26])) : 4'hF);
         if (k[3] && h) chk(last_out, (k[0] & ~d & mode[a[27:26]])
            ? {a, ~a} : {32'h00000000, ~a});
         @(posedge clk);
         #1;
      end
   endtask
   // both masters at once while the receiver stalls, then a refused third
   task t_arb;
      reg g1, g2;
      begin
         rr = 1'b0;
         {cv, ca, dv, da} = {1'b1, 32'h04000010, 1'b1, 32'h08000020};
         for (n = 0; n < 80 && (cv | dv); n++) begin
            @(negedge clk);
            {g1, g2} = {cr, dr};
            @(posedge clk);
            #1;
            if (g1 === 1'b1) cv = 1'b0;
            if (g2 === 1'b1) dv = 1'b0;
         end
         if (cv | dv) begin
            num_errors++;
            finish_test;
         end
         {cv, g1} = 2'h2;
         repeat (40) begin
            @(negedge clk);
            g1 = g1 | (cr === 1'b1);
         end
         chk(g1, 1'b0);
         chk({rv, rd, rdata}, {2'h2, 64'h04000010});
         @(posedge clk);
         #1;
         rr = 1'b1;
         @(posedge clk);
         #1;
         chk({rv, rd, rdata}, {2'h3, 64'h08000020});
         req(0, 4'h0, 1, 32'h04000010);
      end
   endtask
   task t_async;
      begin
         req(0, 4'h0, 1, 32'h00200000);
         req(1, 4'h0, 1, 32'h007FFFFF);
         req(0, 4'h0, 0, 32'h00800000);
         req(0, 4'h0, 0, 32'h001FFFFF);
         req(1, 4'h1, 1, 32'h047FFFFF);
         req(0, 4'h0, 0, 32'h04800000);
         req(0, 4'h8, 1, 32'h0800ABCD);
         req(1, 4'h0, 1, 32'h0C000000);
         req(0, 4'h0, 0, 32'h0C800000);
      end
   endtask
   task t_sdram;
      begin
         {mode, size} = {4'hA, 12'hD86};
         req(0, 4'h0, 1, 32'h040FFFFF);
         req(1, 4'h0, 0, 32'h04100000);
         req(0, 4'h1, 1, 32'h0FFFFFFF);
         req(1, 4'h8, 1, 32'h0C000040);
         req(0, 4'h0, 1, 32'h087FFFFF);
         req(0, 4'h9, 1, 32'h0C000080);
         // bank 1 at 16M bytes, bank 3 with a code above the largest
         size = 12'hF96;
         req(0, 4'h0, 1, 32'h043FFFFF);
         req(1, 4'h0, 0, 32'h04400000);
         req(0, 4'h0, 1, 32'h0EFFFFFF);
      end
   endtask
   task t_fetch;
      begin
         {mode, size} = {4'hF, 12'hDB6};
         req(0, 4'h0, 1, 32'h03FFFFFF);
         req(0, 4'h4, 1, 32'h005FFFFF);
         req(0, 4'h4, 0, 32'h00600000);
         req(0, 4'h6, 1, 32'h00600000);
         req(0, 4'h6, 1, 32'h00FFFFFF);
         req(0, 4'h6, 0, 32'h005FFFFF);
         req(0, 4'h4, 0, 32'h04000000);
         req(0, 4'h4, 1, 32'h00200000);
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      t_arb;
      t_async;
      t_sdram;
      t_fetch;
      finish_test;
   end
endmodule // testbench
